// ===== tcm_pkg.sv
// constants, register layout and state types of the channel one mode control block
package tcm_pkg;

	// ****************************************************************
	// register bus
	// ****************************************************************
	localparam int             ADDR_W          = 4;
	localparam int             DATA_W          = 16;
	localparam logic [3:0]     CFG_OFFSET      = 4'h0;   // channel1_mode_config
	localparam logic [7:0]     CFG_RESET       = 8'h00;
	localparam logic [15:0]    RD_IDLE         = 16'h0000;

	// ****************************************************************
	// field positions of channel1_mode_config
	// ****************************************************************
	localparam int             DIR_LSB         = 0;      // channel_direction_sel, 1:0
	localparam int             PSC_LSB         = 2;      // capture_event_divider, 3:2
	localparam int             MODE_LSB        = 4;      // compare_mode_sel, 6:4
	localparam int             FILT_LSB        = 4;      // input_filter_sel, 7:4
	localparam int             FILT_MSB        = 7;
	localparam int             OUT_VIEW_BITS   = 7;      // bits 15:7 reserved in output view
	localparam int             IN_VIEW_BITS    = 8;      // bits 15:8 reserved in input view

	// ****************************************************************
	// encodings
	// ****************************************************************
	localparam logic [1:0]     DIR_OUTPUT      = 2'h0;
	localparam logic [1:0]     DIR_LINE_ONE    = 2'h1;
	localparam logic [1:0]     DIR_LINE_TWO    = 2'h2;
	localparam logic [1:0]     DIR_TRIGGER     = 2'h3;
	localparam logic [1:0]     LOCK_FULL       = 2'h3;

	localparam logic [2:0]     MODE_FROZEN     = 3'h0;
	localparam logic [2:0]     MODE_SET_MATCH  = 3'h1;
	localparam logic [2:0]     MODE_CLR_MATCH  = 3'h2;
	localparam logic [2:0]     MODE_TOGGLE     = 3'h3;
	localparam logic [2:0]     MODE_FORCE_LOW  = 3'h4;
	localparam logic [2:0]     MODE_FORCE_HIGH = 3'h5;
	localparam logic [2:0]     MODE_PWM_ONE    = 3'h6;
	localparam logic [2:0]     MODE_PWM_TWO    = 3'h7;

	// ****************************************************************
	// filter tables, indexed by input_filter_sel (element 0 rightmost)
	// ****************************************************************
	// divider as a power of two: 1,1,1,1,2,2,4,4,8,8,16,16,16,32,32,32
	localparam logic [15:0][2:0] FILT_DIV_LOG2 = {
		3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3,
		3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
	// consecutive agreeing samples; code 0 takes every sample at once
	localparam logic [15:0][3:0] FILT_LEN = {
		4'h8, 4'h6, 4'h5, 4'h8, 4'h6, 4'h5, 4'h8, 4'h6,
		4'h8, 4'h6, 4'h8, 4'h6, 4'h8, 4'h4, 4'h2, 4'h1};
	localparam logic [4:0]     DIV_ALL_ONES    = 5'h1F;
	localparam logic [2:0]     DIV_LOG2_MAX    = 3'h5;

	// ****************************************************************
	// carriers and state
	// ****************************************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
		logic              wr;
		logic              rd;
	} tcm_bus_req_t;

	typedef struct packed {
		logic [4:0] divCount;
		logic [3:0] agreeCount;
		logic       level;
	} tcm_filt_state_t;

	typedef struct packed {
		logic [7:0]        cfg;
		logic [DATA_W-1:0] rdData;
		logic              refLevel;
		logic [1:0]        syncOne;
		logic [1:0]        syncTwo;
		logic [1:0]        syncThree;
		logic [1:0]        lineLevel;
		logic              capPrev;
		logic [2:0]        pscCount;
		logic              capturePulse;
		logic [15:0]       captureValue;
	} tcm_main_state_t;

endpackage : tcm_pkg

// ===== tcm_input_filter.sv
// digital input filter with sampling divider and agreement length
`timescale 1ns/1ps
module tcm_input_filter (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       sampleIn,
	input  wire logic [3:0] filterSel,
	output logic            level
);

	tcm_pkg::tcm_filt_state_t q, d;
	logic [2:0] divLog2;
	logic [3:0] lenNeed;
	logic [4:0] divMask;
	logic       sampleTick;

	// ****************************************************************
	// filter state update
	// ****************************************************************
	// table lookups and sampling tick from the divider count
	always_comb begin
		divLog2    = tcm_pkg::FILT_DIV_LOG2[filterSel];
		lenNeed    = tcm_pkg::FILT_LEN[filterSel];
		divMask    = tcm_pkg::DIV_ALL_ONES >> (tcm_pkg::DIV_LOG2_MAX - divLog2);
		sampleTick = (q.divCount & divMask) == divMask;
		d = q;
		d.divCount = sampleTick ? 5'h00 : 5'(q.divCount + 5'h01);
		// a transition is taken only once lenNeed samples in a row disagree with the level
		if (sampleTick) begin
			if (sampleIn == q.level) begin
				d.agreeCount = 4'h0;
			end else if (4'(q.agreeCount + 4'h1) >= lenNeed) begin
				d.level      = sampleIn;
				d.agreeCount = 4'h0;
			end else begin
				d.agreeCount = 4'(q.agreeCount + 4'h1);
			end
		end
	end

	// register the filter state
	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.level;

endmodule : tcm_input_filter

// ===== tcm_chan_mode.sv
// channel one mode control: direction, compare reference, capture prescaler and filter
`timescale 1ns/1ps
module tcm_chan_mode (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire tcm_pkg::tcm_bus_req_t busReq,
	output logic [15:0]                busRdData,
	input  wire logic                  channelEnableBit,
	input  wire logic [1:0]            lockLevel,
	input  wire logic [15:0]           counterValue,
	input  wire logic [15:0]           compareValue,
	input  wire logic                  inputLineOne,
	input  wire logic                  inputLineTwo,
	input  wire logic                  internalTriggerSource,
	output logic                       channelReferenceLevel,
	output logic                       captureInputSignal,
	output logic                       captureEvent,
	output logic [15:0]                captureValue
);

	tcm_pkg::tcm_main_state_t q, d;

	logic [1:0] dirSel;
	logic [1:0] pscSel;
	logic [2:0] modeSel;
	logic [3:0] filterSel;
	logic       isOutput;
	logic       cfgHit;
	logic       counterMatch;
	logic       counterBelow;
	logic       counterAbove;
	logic       filterIn;
	logic       filterLevel;
	logic       risingEdge;
	logic [2:0] pscLast;

	// ****************************************************************
	// field views of the configuration byte
	// ****************************************************************
	// the mode and filter fields share bits, the direction decides which one counts
	always_comb begin
		dirSel    = q.cfg[tcm_pkg::DIR_LSB +: 2];
		pscSel    = q.cfg[tcm_pkg::PSC_LSB +: 2];
		modeSel   = q.cfg[tcm_pkg::MODE_LSB +: 3];
		filterSel = q.cfg[tcm_pkg::FILT_LSB +: 4];
		isOutput  = dirSel == tcm_pkg::DIR_OUTPUT;
		cfgHit    = busReq.addr == tcm_pkg::CFG_OFFSET;
	end

	// ****************************************************************
	// compare results against the counter
	// ****************************************************************
	// plain magnitude compares; the counter itself lives outside this block
	always_comb begin
		counterMatch = counterValue == compareValue;
		counterBelow = counterValue <  compareValue;
		counterAbove = counterValue >  compareValue;
	end

	// ****************************************************************
	// capture source selection and filter
	// ****************************************************************
	// pins are taken from the synchronised level; the trigger is same-clock logic
	always_comb begin
		if (dirSel == tcm_pkg::DIR_LINE_ONE) begin
			filterIn = q.lineLevel[0];
		end else if (dirSel == tcm_pkg::DIR_LINE_TWO) begin
			filterIn = q.lineLevel[1];
		end else if (dirSel == tcm_pkg::DIR_TRIGGER) begin
			filterIn = internalTriggerSource;
		end else begin
			filterIn = 1'b0;
		end
	end

	// code 0000 maps to divider 1 and length 1, so every clock sample passes
	tcm_input_filter u_filter (
		.clk       (clk),
		.srst      (srst),
		.sampleIn  (filterIn),
		.filterSel (filterSel),
		.level     (filterLevel)
	);

	// valid event is a rising edge of the filtered input; polarity is handled elsewhere
	always_comb begin
		risingEdge = filterLevel & ~q.capPrev;
		pscLast    = 3'((4'h1 << pscSel) - 4'h1);
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		d.rdData       = tcm_pkg::RD_IDLE;
		d.capturePulse = 1'b0;

		// pin synchronisers: three stages, a change counts once stages two and three agree
		d.syncOne   = {inputLineTwo, inputLineOne};
		d.syncTwo   = q.syncOne;
		d.syncThree = q.syncTwo;
		for (int i = 0; i < 2; i++) begin
			if (q.syncTwo[i] == q.syncThree[i]) begin
				d.lineLevel[i] = q.syncThree[i];
			end
		end

		// register write; direction lands only while the channel is disabled, mode and bit 7 are guarded against the current direction, prescaler always lands
		if (busReq.wr && cfgHit) begin
			if (!channelEnableBit) begin
				d.cfg[tcm_pkg::DIR_LSB +: 2] = busReq.wrData[tcm_pkg::DIR_LSB +: 2];
			end
			d.cfg[tcm_pkg::PSC_LSB +: 2] = busReq.wrData[tcm_pkg::PSC_LSB +: 2];
			if (!(isOutput && lockLevel == tcm_pkg::LOCK_FULL)) begin
				d.cfg[tcm_pkg::MODE_LSB +: 3] = busReq.wrData[tcm_pkg::MODE_LSB +: 3];
			end
			// top filter bit is reserved in the output view, so it only lands in input view
			if (!isOutput) begin
				d.cfg[tcm_pkg::FILT_MSB] = busReq.wrData[tcm_pkg::FILT_MSB];
			end
		end

		// register read; the layout depends on the direction, reserved bits read zero
		if (busReq.rd && cfgHit) begin
			if (isOutput) begin
				d.rdData = {9'h000, q.cfg[tcm_pkg::OUT_VIEW_BITS-1:0]};
			end else begin
				d.rdData = {8'h00, q.cfg[tcm_pkg::IN_VIEW_BITS-1:0]};
			end
		end

		// compare reference; PWM levels are recomputed every cycle, so a change of
		// compare result or of mode out of frozen shows on the next edge
		if (isOutput) begin
			case (modeSel)
				tcm_pkg::MODE_FROZEN: begin
					d.refLevel = q.refLevel;
				end
				tcm_pkg::MODE_SET_MATCH: begin
					if (counterMatch) begin
						d.refLevel = 1'b1;
					end
				end
				tcm_pkg::MODE_CLR_MATCH: begin
					if (counterMatch) begin
						d.refLevel = 1'b0;
					end
				end
				tcm_pkg::MODE_TOGGLE: begin
					if (counterMatch) begin
						d.refLevel = ~q.refLevel;
					end
				end
				tcm_pkg::MODE_FORCE_LOW: begin
					d.refLevel = 1'b0;
				end
				tcm_pkg::MODE_FORCE_HIGH: begin
					d.refLevel = 1'b1;
				end
				tcm_pkg::MODE_PWM_ONE: begin
					d.refLevel = counterBelow;
				end
				default: begin
					d.refLevel = counterAbove;
				end
			endcase
		end

		// capture path: prescale valid events, take the counter only while enabled
		d.capPrev = filterLevel;
		if (isOutput || !channelEnableBit) begin
			d.pscCount = 3'h0;
		end else if (risingEdge) begin
			if (q.pscCount >= pscLast) begin
				d.pscCount     = 3'h0;
				d.capturePulse = 1'b1;
				d.captureValue = counterValue;
			end else begin
				d.pscCount = 3'(q.pscCount + 3'h1);
			end
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			q     <= '0;
			q.cfg <= tcm_pkg::CFG_RESET;
		end else begin
			q <= d;
		end
	end

	// all outputs come from the state flops or the filter's flop
	assign busRdData             = q.rdData;
	assign channelReferenceLevel = q.refLevel;
	assign captureInputSignal    = filterLevel;
	assign captureEvent          = q.capturePulse;
	assign captureValue          = q.captureValue;

endmodule : tcm_chan_mode

// ===== tcm_chan_mode_assertions.sv
// assertion checker bound to the channel one mode control ports
`timescale 1ns/1ps
module tcm_chan_mode_assertions (
	input wire logic                  clk,
	input wire logic                  srst,
	input wire tcm_pkg::tcm_bus_req_t busReq,
	input wire logic [15:0]           busRdData,
	input wire logic                  channelEnableBit,
	input wire logic [1:0]            lockLevel,
	input wire logic [15:0]           counterValue,
	input wire logic [15:0]           compareValue,
	input wire logic                  channelReferenceLevel,
	input wire logic                  captureInputSignal,
	input wire logic                  captureEvent,
	input wire logic [15:0]           captureValue
);
	logic [7:0] cfgShadowQ;
	logic       outView;
	logic [2:0] mode;
	logic       belowCmp;

	// ****************************************************************
	// shadow of the config register
	// ****************************************************************
	// refusals mirrored here so that mode checks track what really landed
	always_ff @(posedge clk) begin
		if (srst)
			cfgShadowQ <= 8'h00;
		else if (busReq.wr && busReq.addr == tcm_pkg::CFG_OFFSET) begin
			if (!channelEnableBit)
				cfgShadowQ[1:0] <= busReq.wrData[1:0];
			cfgShadowQ[3:2] <= busReq.wrData[3:2];
			if (!(lockLevel == tcm_pkg::LOCK_FULL && outView))
				cfgShadowQ[6:4] <= busReq.wrData[6:4];
			if (!outView)
				cfgShadowQ[7] <= busReq.wrData[7];
		end
	end
	// decoded view of the shadow
	assign outView  = (cfgShadowQ[1:0] == tcm_pkg::DIR_OUTPUT);
	assign mode     = cfgShadowQ[6:4];
	assign belowCmp = (counterValue < compareValue);

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_rd_idle:
	assert property ((!$past(busReq.rd) || $past(busReq.addr) != tcm_pkg::CFG_OFFSET)
		|-> busRdData == 16'h0000) else $error("read data not idle");
	chk_rd_reserved:
	assert property (busRdData[15:8] == 8'h00) else $error("reserved read bits set");
	chk_rd_outview:
	assert property ($past(outView) |-> !busRdData[7]) else $error("bit 7 shown in output view");
	chk_frozen_hold:
	assert property (outView && mode == tcm_pkg::MODE_FROZEN |=> $stable(channelReferenceLevel))
		else $error("frozen mode moved the level");
	chk_set_match:
	assert property (outView && mode == tcm_pkg::MODE_SET_MATCH && counterValue == compareValue
		|=> channelReferenceLevel) else $error("match did not set level");
	chk_toggle_match:
	assert property (outView && mode == tcm_pkg::MODE_TOGGLE && counterValue == compareValue
		|=> channelReferenceLevel != $past(channelReferenceLevel)) else $error("no toggle");
	chk_force_low:
	assert property (outView && mode == tcm_pkg::MODE_FORCE_LOW |=> !channelReferenceLevel)
		else $error("forced low not held");
	chk_pwm_one:
	assert property (outView && mode == tcm_pkg::MODE_PWM_ONE
		|=> channelReferenceLevel == $past(belowCmp)) else $error("first pwm level wrong");
	chk_input_hold:
	assert property (!outView |=> $stable(channelReferenceLevel)) else $error("input moved level");
	chk_event_pulse:
	assert property (captureEvent |=> !captureEvent) else $error("capture event too long");
	chk_event_cause:
	assert property (captureEvent |-> $past(captureInputSignal) && !$past(captureInputSignal, 2)
		&& $past(channelEnableBit) && !$past(outView)) else $error("capture without cause");
	chk_cap_value:
	assert property (captureEvent |-> captureValue == $past(counterValue))
		else $error("captured value wrong");
endmodule : tcm_chan_mode_assertions

bind tcm_chan_mode tcm_chan_mode_assertions chk_u (.clk(clk), .srst(srst), .busReq(busReq),
	.busRdData(busRdData), .channelEnableBit(channelEnableBit), .lockLevel(lockLevel),
	.counterValue(counterValue), .compareValue(compareValue),
	.channelReferenceLevel(channelReferenceLevel), .captureInputSignal(captureInputSignal),
	.captureEvent(captureEvent), .captureValue(captureValue));

// ===== tb_top.sv
// self-checking testbench of the channel one mode control block
`timescale 1ns/1ps
module tb_top;
	logic                  clk;
	logic                  srst;
	tcm_pkg::tcm_bus_req_t busReq;
	logic [15:0]           busRdData;
	logic                  channelEnableBit;
	logic [1:0]            lockLevel;
	logic [15:0]           counterValue;
	logic [15:0]           compareValue;
	logic                  inputLineOne;
	logic                  inputLineTwo;
	logic                  internalTriggerSource;
	logic                  channelReferenceLevel;
	logic                  captureInputSignal;
	logic                  captureEvent;
	logic [15:0]           captureValue;
	int                    numErrors;
	int                    nTests;

	tcm_chan_mode dut_u (.clk(clk), .srst(srst), .busReq(busReq), .busRdData(busRdData),
		.channelEnableBit(channelEnableBit), .lockLevel(lockLevel), .counterValue(counterValue),
		.compareValue(compareValue), .inputLineOne(inputLineOne), .inputLineTwo(inputLineTwo),
		.internalTriggerSource(internalTriggerSource),
		.channelReferenceLevel(channelReferenceLevel), .captureInputSignal(captureInputSignal),
		.captureEvent(captureEvent), .captureValue(captureValue));

	// 250 MHz clock
	always #2 clk = ~clk;

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		nTests++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			numErrors++;
		end
	endtask : check

	task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		busReq.wr <= 1'b0;
	endtask : bus_wr

	// read data stand only in the cycle after the strobe, so look just after that edge
	task automatic rd_check(input string what, input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		busReq <= '{addr: a, wrData: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		busReq.rd <= 1'b0;
		#1 check(what, exp, busRdData);
	endtask : rd_check

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	// pulses the selected source and counts capture events; enable dropped to rewrite direction
	task automatic cap_run(input logic [7:0] cfg, input logic en, input int n, input int width,
		input int expN);
		int   seen;
		logic hi;
		seen = 0;
		@(posedge clk);
		channelEnableBit <= 1'b0;
		// the second write lands bit 7, which the output view refuses on the first
		bus_wr(4'h0, {8'h00, cfg});
		bus_wr(4'h0, {8'h00, cfg});
		@(posedge clk);
		channelEnableBit <= en;
		for (int i = 0; i < 2 * n * width; i++) begin
			hi = ((i / width) % 2 == 0);
			@(posedge clk);
			inputLineOne <= hi && cfg[1:0] == tcm_pkg::DIR_LINE_ONE;
			inputLineTwo <= hi && cfg[1:0] == tcm_pkg::DIR_LINE_TWO;
			internalTriggerSource <= hi && cfg[1:0] == tcm_pkg::DIR_TRIGGER;
			counterValue <= counterValue + 16'h0001;
			@(negedge clk);
			// the counter steps every cycle, so the captured value is one behind it
			if (captureEvent === 1'b1) begin
				seen++;
				check("capture value", 16'(counterValue - 16'h0001), captureValue);
				check("capture input", 16'h0001, {15'h0, captureInputSignal});
			end
		end
		check($sformatf("capture count cfg %h", cfg), 16'(expN), 16'(seen));
	endtask : cap_run

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset;
		rd_check("config after reset", 4'h0, 16'h0000);
		check("level after reset", 16'h0000, {15'h0, channelReferenceLevel});
		$display("test reset done");
	endtask : t_reset

	// each mode starts from a known level so that a frozen or wrong mode shows
	task automatic t_compare;
		logic [2:0]  pre [8] = '{3'h5, 3'h4, 3'h5, 3'h4, 3'h5, 3'h4, 3'h0, 3'h4};
		logic [15:0] cnt [8] = '{16'h000A, 16'h000A, 16'h000A, 16'h000A, 16'h000A, 16'h000A,
			16'h0014, 16'h0014};
		logic        exp [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		logic [15:0] got;
		for (int m = 0; m < 8; m++) begin
			@(posedge clk);
			counterValue <= 16'h0000;
			bus_wr(4'h0, {9'h000, pre[m], 4'h0});
			bus_wr(4'h0, {9'h000, 3'(m), 4'h0});
			@(posedge clk);
			counterValue <= cnt[m];
			// one-cycle match, or a toggle mode would flip on every cycle
			if (m < 4) begin
				@(posedge clk);
				counterValue <= 16'h0000;
			end
			repeat (3) @(posedge clk);
			#1 got = {15'h0, channelReferenceLevel};
			case (m)
				0: check("level frozen", {15'h0, exp[m]}, got);
				1: check("level set on match", {15'h0, exp[m]}, got);
				2: check("level clear on match", {15'h0, exp[m]}, got);
				3: check("level toggle on match", {15'h0, exp[m]}, got);
				4: check("level forced low", {15'h0, exp[m]}, got);
				5: check("level forced high", {15'h0, exp[m]}, got);
				6: check("level first pwm", {15'h0, exp[m]}, got);
				default: check("level second pwm", {15'h0, exp[m]}, got);
			endcase
		end
		$display("test compare modes done");
	endtask : t_compare

	task automatic t_lock;
		bus_wr(4'h0, 16'h0050);
		@(posedge clk);
		lockLevel <= tcm_pkg::LOCK_FULL;
		bus_wr(4'h0, 16'h004C);
		rd_check("locked mode write", 4'h0, 16'h005C);
		@(posedge clk);
		lockLevel <= 2'h0;
		$display("test lock done");
	endtask : t_lock

	task automatic t_direction;
		@(posedge clk);
		channelEnableBit <= 1'b1;
		bus_wr(4'h0, 16'h0001);
		rd_check("direction while enabled", 4'h0, 16'h0000);
		@(posedge clk);
		channelEnableBit <= 1'b0;
		bus_wr(4'h0, 16'h0001);
		bus_wr(4'h0, 16'hFFF5);
		rd_check("input view", 4'h0, 16'h00F5);
		bus_wr(4'h0, 16'h00F0);
		rd_check("output view", 4'h0, 16'h0070);
		rd_check("unmapped read", 4'h7, 16'h0000);
		$display("test direction done");
	endtask : t_direction

	task automatic t_capture;
		for (int k = 0; k < 4; k++)
			cap_run({4'h0, 2'(k), 2'h1}, 1'b1, 8, 10, 8 >> k);
		cap_run(8'h02, 1'b1, 2, 10, 2);
		cap_run(8'h03, 1'b1, 2, 10, 2);
		cap_run(8'h01, 1'b0, 2, 10, 0);
		$display("test capture done");
	endtask : t_capture

	task automatic t_filter;
		cap_run(8'h31, 1'b1, 2, 4, 0);
		cap_run(8'h31, 1'b1, 2, 20, 2);
		cap_run(8'hF1, 1'b1, 1, 100, 0);
		cap_run(8'hF1, 1'b1, 1, 400, 1);
		$display("test filter done");
	endtask : t_filter

	// main sequence
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		busReq = '0;
		{channelEnableBit, lockLevel, counterValue} = '0;
		{inputLineOne, inputLineTwo, internalTriggerSource} = 3'h0;
		compareValue = 16'h000A;
		numErrors = 0;
		nTests = 0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_compare;
		t_lock;
		t_direction;
		t_capture;
		t_filter;
		give_verdict;
	end

	// watchdog, about ten times the expected run
	initial begin
		repeat (20000) @(posedge clk);
		numErrors++;
		give_verdict;
	end
endmodule : tb_top
